// ### hw/mts_down_timer.v
`timescale 1ns/1ps
// 8-bit auto-reload down counter used by the prescaler and both timers
module mts_down_timer #(
  parameter WIDTH = 8
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_run,
  input wire i_clear,
  input wire i_count,
  input wire i_load,
  input wire [WIDTH-1:0] i_load_value,
  input wire [WIDTH-1:0] i_reload,
  output reg [WIDTH-1:0] o_value,
  output wire o_underflow
);
  // underflow at zero count: n+1 pulses per period
  assign o_underflow = i_run & i_count & (o_value == {WIDTH{1'b0}});

  // reload on the underflow pulse, so none is lost
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_value <= {WIDTH{1'b1}};
    else if (i_clear)
      o_value <= i_reload;
    else if (i_load)
      o_value <= i_load_value;
    else if (o_underflow)
      o_value <= i_reload;
    else if (i_run & i_count)
      o_value <= o_value - {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule // mts_down_timer

// ### hw/mts_timer_top.v
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "mts_defines.vh"
module mts_timer_top #(
  parameter INST_DIV = 4,
  parameter WDOG_RATIO = 65536
) (
  input wire I_MCLK,
  input wire I_RST_B,
  input wire [3:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire I_RING_CLK,
  input wire I_CNTR_FIRST,
  input wire I_CNTR_SECOND,
  input wire I_INT_PIN,
  output reg [15:0] O_RDATA,
  output reg O_CNTR_FIRST,
  output reg O_CNTR_FIRST_OE_B,
  output reg O_CNTR_SECOND,
  output reg O_CNTR_SECOND_OE_B,
  output wire O_IRQ,
  output reg O_WDOG_FLAG,
  output reg O_SYS_RESET
);
  localparam [15:0] WDOG_LAST = WDOG_RATIO[15:0] - 16'h0001;

  // Reset release through two flops
  reg rst_s1;
  reg rst_s2;
  always @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_b = rst_s2;

  // Pin inputs pass two flops; stage one is read only by stage two
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  reg [3:0] pin_s3;
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_s3 <= 4'h0;
    end
    else
    begin
      pin_s1 <= {I_INT_PIN, I_RING_CLK, I_CNTR_SECOND, I_CNTR_FIRST};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  wire [3:0] rise = pin_s2 & ~pin_s3;
  wire [3:0] fall = ~pin_s2 & pin_s3;

  // Edge select shared by both counter pins
  function edge_pick;
    input rise_in;
    input fall_in;
    input use_rise;
    begin
      edge_pick = use_rise ? rise_in : fall_in;
    end
  endfunction

  // Control registers
  reg [3:0] prescaler_control_reg;
  reg [3:0] timer1_control_reg;
  reg [3:0] timer2_control_reg;
  reg [3:0] pin_control_reg_a;
  reg [3:0] pin_control_reg_b;
  reg [7:0] presc_reload;
  reg [7:0] t1_reload;
  reg [7:0] t2_reload;
  reg [2:0] irq_status;
  reg [2:0] irq_enable;

  wire wr_t1_count = I_WR & (I_ADDR == `MTS_OFF_T1_COUNT);
  wire wr_t2_count = I_WR & (I_ADDR == `MTS_OFF_T2_COUNT);
  wire wr_clear = I_WR & (I_ADDR == `MTS_OFF_IRQ_CLEAR);
  wire wr_wdog = I_WR & (I_ADDR == `MTS_OFF_WDOG);

  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescaler_control_reg <= `MTS_CTL_RESET;
      timer1_control_reg <= `MTS_CTL_RESET;
      timer2_control_reg <= `MTS_CTL_RESET;
      pin_control_reg_a <= `MTS_CTL_RESET;
      pin_control_reg_b <= `MTS_CTL_RESET;
      presc_reload <= `MTS_RELOAD_RESET;
      t1_reload <= `MTS_RELOAD_RESET;
      t2_reload <= `MTS_RELOAD_RESET;
      irq_enable <= 3'h0;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        `MTS_OFF_PRESC_CTL: prescaler_control_reg <= I_WDATA[3:0];
        `MTS_OFF_T1_CTL: timer1_control_reg <= I_WDATA[3:0];
        `MTS_OFF_T2_CTL: timer2_control_reg <= I_WDATA[3:0];
        `MTS_OFF_PIN_A: pin_control_reg_a <= I_WDATA[3:0];
        `MTS_OFF_PIN_B: pin_control_reg_b <= I_WDATA[3:0];
        `MTS_OFF_PRESC_RELOAD: presc_reload <= I_WDATA[7:0];
        `MTS_OFF_T1_RELOAD: t1_reload <= I_WDATA[7:0];
        `MTS_OFF_T2_RELOAD: t2_reload <= I_WDATA[7:0];
        `MTS_OFF_IRQ_ENABLE: irq_enable <= I_WDATA[2:0];
        default: ;
      endcase
    end
  end

  wire prescaler_run_bit = prescaler_control_reg[0];
  wire timer1_run_bit = timer1_control_reg[`MTS_BIT_RUN];
  wire timer2_run_bit = timer2_control_reg[`MTS_BIT_RUN];

  // Instruction clock: one enable pulse every INST_DIV system clocks
  reg [7:0] inst_cnt;
  wire instruction_clock = (inst_cnt == INST_DIV[7:0] - 8'h01);
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
      inst_cnt <= 8'h00;
    else if (instruction_clock)
      inst_cnt <= 8'h00;
    else
      inst_cnt <= inst_cnt + 8'h01;
  end

  wire prescaler_output;
  mts_down_timer #(.WIDTH(8)) u_presc (
    .i_clk(I_MCLK),
    .i_rst_b(rst_b),
    .i_run(prescaler_run_bit),
    .i_clear(~prescaler_run_bit),
    .i_count(instruction_clock),
    .i_load(1'b0),
    .i_load_value(8'h00),
    .i_reload(presc_reload),
    .o_value(),
    .o_underflow(prescaler_output)
  );

  wire counter_pin_first = edge_pick(rise[0], fall[0], pin_control_reg_a[`MTS_BIT_EDGE]);
  wire counter_pin_second = edge_pick(rise[1], fall[1], pin_control_reg_a[`MTS_BIT_EDGE]);
  wire ring_edge = rise[2];
  wire int_edge = rise[3] | fall[3];

  // PWM toggles on each underflow; used only as pin output, the underflow itself is the cross source
  reg timer1_pwm_signal;
  reg timer2_pwm_signal;
  wire timer1_underflow;
  wire timer2_underflow;
  wire [7:0] t1_value;
  wire [7:0] t2_value;

  reg t1_src;
  always @*
  begin
    case (timer1_control_reg[1:0])
      2'b00: t1_src = timer2_underflow;
      2'b01: t1_src = prescaler_output;
      2'b10: t1_src = counter_pin_second;
      2'b11: t1_src = ring_edge;
      default: t1_src = 1'b0;
    endcase
  end

  reg t2_src;
  always @*
  begin
    case (timer2_control_reg[1:0])
      2'b00: t2_src = timer1_underflow;
      2'b01: t2_src = prescaler_output;
      2'b10: t2_src = counter_pin_first;
      2'b11: t2_src = 1'b1;
      default: t2_src = 1'b0;
    endcase
  end

  // timer one gated by INT level when linked
  wire t1_gate = ~pin_control_reg_a[`MTS_BIT_T1_INT_LINK] | pin_s2[3];
  // stop retains count; inside the counter
  mts_down_timer #(.WIDTH(8)) u_t1 (
    .i_clk(I_MCLK),
    .i_rst_b(rst_b),
    .i_run(timer1_run_bit & t1_gate),
    .i_clear(1'b0),
    .i_count(t1_src),
    .i_load(wr_t1_count),
    .i_load_value(I_WDATA[7:0]),
    .i_reload(t1_reload),
    .o_value(t1_value),
    .o_underflow(timer1_underflow)
  );

  // period mode restarts timer two on each INT edge
  wire t2_period = pin_control_reg_b[`MTS_BIT_T2_INT_PERIOD];
  reg [7:0] t2_captured;
  mts_down_timer #(.WIDTH(8)) u_t2 (
    .i_clk(I_MCLK),
    .i_rst_b(rst_b),
    .i_run(timer2_run_bit),
    .i_clear(t2_period & int_edge),
    .i_count(t2_src),
    .i_load(wr_t2_count),
    .i_load_value(I_WDATA[7:0]),
    .i_reload(t2_reload),
    .o_value(t2_value),
    .o_underflow(timer2_underflow)
  );

  // Period capture and PWM toggles
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t2_captured <= 8'h00;
      timer1_pwm_signal <= 1'b0;
      timer2_pwm_signal <= 1'b0;
    end
    else
    begin
      if (t2_period & int_edge)
        t2_captured <= t2_value;
      if (timer1_underflow)
        timer1_pwm_signal <= ~timer1_pwm_signal;
      if (timer2_underflow)
        timer2_pwm_signal <= ~timer2_pwm_signal;
    end
  end

  // pin drivers: PWM level when enabled, else underflow pulse
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      O_CNTR_FIRST <= 1'b0;
      O_CNTR_SECOND <= 1'b0;
      O_CNTR_FIRST_OE_B <= 1'b1;
      O_CNTR_SECOND_OE_B <= 1'b1;
    end
    else
    begin
      O_CNTR_FIRST <= timer1_control_reg[`MTS_BIT_PWM] ? timer1_pwm_signal : timer1_underflow;
      O_CNTR_SECOND <= timer2_control_reg[`MTS_BIT_PWM] ? timer2_pwm_signal : timer2_underflow;
      O_CNTR_FIRST_OE_B <= ~pin_control_reg_a[`MTS_BIT_PIN_OE];
      O_CNTR_SECOND_OE_B <= ~pin_control_reg_b[`MTS_BIT_PIN_OE];
    end
  end

  reg [15:0] free_cnt;
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
      free_cnt <= 16'h0000;
    else
      free_cnt <= free_cnt + 16'h0001;
  end

  // watchdog: flag on first terminal count, reset on second
  reg [15:0] wdog_cnt;
  wire wdog_tc = instruction_clock & (wdog_cnt == 16'h0000);
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdog_cnt <= WDOG_LAST;
      O_WDOG_FLAG <= 1'b0;
      O_SYS_RESET <= 1'b0;
    end
    else
    begin
      // Kick restarts the count and drops the flag; a terminal count wins
      if (wdog_tc)
        wdog_cnt <= WDOG_LAST;
      else if (wr_wdog)
        wdog_cnt <= WDOG_LAST;
      else if (instruction_clock)
        wdog_cnt <= wdog_cnt - 16'h0001;
      if (wdog_tc)
        O_WDOG_FLAG <= 1'b1;
      else if (wr_wdog)
        O_WDOG_FLAG <= 1'b0;
      if (wdog_tc & O_WDOG_FLAG)
        O_SYS_RESET <= 1'b1;
    end
  end

  // separate sticky flags; a set beats a same-cycle clear
  wire [2:0] irq_set = {wdog_tc, timer2_underflow, timer1_underflow};
  wire [2:0] irq_clr = wr_clear ? I_WDATA[2:0] : 3'h0;
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
      irq_status <= 3'h0;
    else
      irq_status <= irq_set | (irq_status & ~irq_clr);
  end
  assign O_IRQ = |(irq_status & irq_enable);

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge I_MCLK or negedge rst_b)
  begin
    if (!rst_b)
      O_RDATA <= 16'h0000;
    else if (I_RD)
    begin
      case (I_ADDR)
        `MTS_OFF_PRESC_CTL: O_RDATA <= {12'h000, prescaler_control_reg};
        `MTS_OFF_T1_CTL: O_RDATA <= {12'h000, timer1_control_reg};
        `MTS_OFF_T2_CTL: O_RDATA <= {12'h000, timer2_control_reg};
        `MTS_OFF_PIN_A: O_RDATA <= {12'h000, pin_control_reg_a};
        `MTS_OFF_PIN_B: O_RDATA <= {12'h000, pin_control_reg_b};
        `MTS_OFF_PRESC_RELOAD: O_RDATA <= {8'h00, presc_reload};
        `MTS_OFF_T1_RELOAD: O_RDATA <= {8'h00, t1_reload};
        `MTS_OFF_T2_RELOAD: O_RDATA <= {8'h00, t2_reload};
        `MTS_OFF_T1_COUNT: O_RDATA <= {8'h00, t1_value};
        `MTS_OFF_T2_COUNT: O_RDATA <= {t2_captured, t2_value};
        `MTS_OFF_IRQ_STATUS: O_RDATA <= {13'h0000, irq_status};
        `MTS_OFF_IRQ_ENABLE: O_RDATA <= {13'h0000, irq_enable};
        `MTS_OFF_FREE_LO: O_RDATA <= free_cnt;
        `MTS_OFF_WDOG: O_RDATA <= {15'h0000, O_WDOG_FLAG};
        default: O_RDATA <= 16'h0000;
      endcase
    end
    else
      O_RDATA <= 16'h0000;
  end
endmodule // mts_timer_top

// ### include/mts_defines.vh
`ifndef MTS_DEFINES_VH
`define MTS_DEFINES_VH
// Register offsets
`define MTS_OFF_PRESC_CTL 4'h0
`define MTS_OFF_T1_CTL 4'h1
`define MTS_OFF_T2_CTL 4'h2
`define MTS_OFF_PIN_A 4'h3
`define MTS_OFF_PIN_B 4'h4
`define MTS_OFF_PRESC_RELOAD 4'h5
`define MTS_OFF_T1_RELOAD 4'h6
`define MTS_OFF_T2_RELOAD 4'h7
`define MTS_OFF_T1_COUNT 4'h8
`define MTS_OFF_T2_COUNT 4'h9
`define MTS_OFF_IRQ_STATUS 4'hA
`define MTS_OFF_IRQ_ENABLE 4'hB
`define MTS_OFF_IRQ_CLEAR 4'hC
`define MTS_OFF_FREE_LO 4'hD
`define MTS_OFF_FREE_HI 4'hE
`define MTS_OFF_WDOG 4'hF
// Control field positions
`define MTS_BIT_RUN 2
`define MTS_BIT_PWM 3
`define MTS_BIT_PIN_OE 3
`define MTS_BIT_EDGE 0
`define MTS_BIT_T1_INT_LINK 1
`define MTS_BIT_T2_INT_PERIOD 1
// Status bits
`define MTS_IRQ_T1 0
`define MTS_IRQ_T2 1
`define MTS_IRQ_WDOG 2
// Reset values
`define MTS_CTL_RESET 4'h0
`define MTS_RELOAD_RESET 8'hFF
`define MTS_WDOG_RESET 16'hFFFF
`endif

// ### testbench/mts_pin_model.sv
`timescale 1ns/1ps
module mts_pin_model (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_run,
  output wire o_ring,
  output wire o_pin_first,
  output wire o_pin_second,
  output wire o_int
);
  logic [3:0] div;
  // Far side stands still while idle, so no stray count edges
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      div <= 4'h0;
    else if (i_run)
      div <= div + 4'h1;
  end
  // Ring toggles each clock, pins every 4 and 8 clocks
  assign o_ring = div[0];
  assign o_pin_first = div[2];
  assign o_pin_second = div[3];
  assign o_int = div[3];
endmodule // mts_pin_model

// ### testbench/mts_timer_assertions.sv
`timescale 1ns/1ps
module mts_timer_chk #(
  parameter INST_DIV = 4,
  parameter WDOG_RATIO = 65536
) (
  input wire I_MCLK,
  input wire I_RST_B,
  input wire [3:0] I_ADDR,
  input wire [15:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [15:0] O_RDATA,
  input wire O_CNTR_FIRST_OE_B,
  input wire O_CNTR_SECOND_OE_B,
  input wire O_IRQ,
  input wire O_WDOG_FLAG,
  input wire O_SYS_RESET
);
  localparam int LIM = INST_DIV * WDOG_RATIO;
  logic [31:0] wcnt;
  logic [2:0] en_sh;
  logic pa3;
  logic pb3;
  // Shadows of software writes; a kick restarts the watchdog age
  always @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      wcnt <= 32'h0;
      en_sh <= 3'h0;
      pa3 <= 1'b0;
      pb3 <= 1'b0;
    end
    else
    begin
      wcnt <= (I_WR && I_ADDR == 4'hF) ? 32'h0 : wcnt + 32'h1;
      if (I_WR && I_ADDR == 4'hB)
        en_sh <= I_WDATA[2:0];
      if (I_WR && I_ADDR == 4'h3)
        pa3 <= I_WDATA[3];
      if (I_WR && I_ADDR == 4'h4)
        pb3 <= I_WDATA[3];
    end
  end
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_kick;
    I_WR && I_ADDR == 4'hF;
  endsequence
  sequence s_rd_rsvd;
    I_RD && I_ADDR == 4'hE;
  endsequence
  rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  rsvd_read_a: assert property (s_rd_rsvd |=> O_RDATA == 16'h0000)
    else $error("reserved index read not zero");
  status_width_a: assert property (I_RD && I_ADDR == 4'hA |=> O_RDATA[15:3] == 13'h0)
    else $error("status upper bits set");
  kick_clear_a: assert property (s_kick |-> ##[1:2] !O_WDOG_FLAG)
    else $error("kick did not clear watchdog flag");
  flag_time_a: assert property ($rose(O_WDOG_FLAG) |-> wcnt >= LIM - 8 && wcnt <= LIM + 8)
    else $error("watchdog flag at wrong time");
  flag_due_a: assert property (wcnt == LIM + 8 |-> O_WDOG_FLAG)
    else $error("watchdog flag missing");
  sysrst_time_a: assert property ($rose(O_SYS_RESET) |-> $past(O_WDOG_FLAG) && wcnt >= 2 * LIM - 8)
    else $error("system reset too early");
  sysrst_hold_a: assert property (O_SYS_RESET |=> O_SYS_RESET)
    else $error("system reset dropped");
  irq_masked_a: assert property (en_sh == 3'h0 && $past(en_sh) == 3'h0 |-> !O_IRQ)
    else $error("interrupt while all masked");
  oe_first_a: assert property (pa3 == $past(pa3) && pa3 == $past(pa3, 2) |-> O_CNTR_FIRST_OE_B == !pa3)
    else $error("first pin enable wrong");
  oe_second_a: assert property (pb3 == $past(pb3) && pb3 == $past(pb3, 2) |-> O_CNTR_SECOND_OE_B == !pb3)
    else $error("second pin enable wrong");
endmodule // mts_timer_chk
bind mts_timer_top mts_timer_chk #(.INST_DIV(INST_DIV), .WDOG_RATIO(WDOG_RATIO)) i_chk (
  .I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .O_CNTR_FIRST_OE_B(O_CNTR_FIRST_OE_B),
  .O_CNTR_SECOND_OE_B(O_CNTR_SECOND_OE_B), .O_IRQ(O_IRQ), .O_WDOG_FLAG(O_WDOG_FLAG),
  .O_SYS_RESET(O_SYS_RESET));

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  logic I_MCLK = 1'b0;
  logic I_RST_B = 1'b0;
  logic [3:0] I_ADDR = 4'h0;
  logic [15:0] I_WDATA = 16'h0000;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic run = 1'b1;
  logic [15:0] d;
  int n_fail = 0;
  int cmp_count = 0;
  wire ring, pf, ps, intp, of, ofe, os, ose, irq, wflag, srst;
  wire [15:0] rdata;
  // Shared pin level: the block wins while its enable is low
  wire pin_f = ofe ? pf : of;
  wire pin_s = ose ? ps : os;
  mts_timer_top #(.INST_DIV(4), .WDOG_RATIO(256)) i_dut (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_RING_CLK(ring),
    .I_CNTR_FIRST(pin_f), .I_CNTR_SECOND(pin_s), .I_INT_PIN(intp), .O_RDATA(rdata),
    .O_CNTR_FIRST(of), .O_CNTR_FIRST_OE_B(ofe), .O_CNTR_SECOND(os), .O_CNTR_SECOND_OE_B(ose),
    .O_IRQ(irq), .O_WDOG_FLAG(wflag), .O_SYS_RESET(srst));
  mts_pin_model i_model (.i_clk(I_MCLK), .i_rst_b(I_RST_B), .i_run(run), .o_ring(ring),
    .o_pin_first(pf), .o_pin_second(ps), .o_int(intp));
  // Clock
  initial
  begin
    forever #4 I_MCLK = ~I_MCLK;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge I_MCLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= v;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge I_MCLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic scn_reset();
    logic [3:0] a[6] = '{4'h5, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE};
    logic [15:0] v;
    for (int i = 0; i < 6; i++)
    begin
      rd(a[i]);
      chk("reset value", (i < 3) ? 16'h00FF : 16'h0000, d);
    end
    chk("pin enable", 16'h0001, {15'h0, ofe});
    rd(4'hD);
    v = d;
    repeat (10) @(posedge I_MCLK);
    rd(4'hD);
    chk("free counter moves", 16'h0001, {15'h0, d != v});
  endtask
  // Every count source of both timers, partner timer running where needed
  task automatic scn_sources();
    wr(4'h6, 16'h0002);
    wr(4'h5, 16'h0000);
    wr(4'h0, 16'h0001);
    wr(4'h3, 16'h0001);
    for (int t = 1; t < 3; t++)
      for (int c = 0; c < 4; c++)
      begin
        wr(4'hF, 16'h0000);
        wr(4'h7, 16'h0002);
        wr(4'hA - t[3:0], 16'h0002);
        wr((c == 0) ? 4'h3 - t[3:0] : 4'h0, (c == 0) ? 16'h0007 : 16'h0001);
        wr(4'h7 + t[3:0], 16'h0002);
        wr(4'hC, 16'h0007);
        wr(t[3:0], 16'h0004 | c[15:0]);
        repeat (80) @(posedge I_MCLK);
        rd(4'hA);
        chk("source underflow", 16'h0001, {15'h0, d[t-1]});
        wr(t[3:0], 16'h0000);
        wr(4'h3 - t[3:0], 16'h0000);
      end
  endtask
  task automatic scn_stop();
    logic [15:0] v;
    wr(4'hF, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h8, 16'h0020);
    wr(4'h1, 16'h0005);
    repeat (40) @(posedge I_MCLK);
    rd(4'h8);
    chk("count, prescaler stopped", 16'h0020, d);
    wr(4'h0, 16'h0001);
    repeat (40) @(posedge I_MCLK);
    wr(4'h1, 16'h0001);
    rd(4'h8);
    v = d;
    chk("count advanced", 16'h0001, {15'h0, v != 16'h0020});
    repeat (40) @(posedge I_MCLK);
    rd(4'h8);
    chk("count held", v, d);
  endtask
  // Rise-to-rise spacing of the underflow pulse is n + 1 clocks
  task automatic scn_period();
    int nv[3] = '{1, 3, 255};
    int k;
    for (int i = 0; i < 3; i++)
    begin
      wr(4'hF, 16'h0000);
      wr(4'h7, 16'(nv[i]));
      wr(4'h9, 16'(nv[i]));
      wr(4'h2, 16'h0007);
      k = 0;
      repeat (600)
      begin
        @(posedge I_MCLK);
        #1;
        if (os === 1'b1)
          break;
      end
      do
      begin
        @(posedge I_MCLK);
        #1 k++;
      end
      while (os !== 1'b1 && k < 600);
      chk("underflow period", 16'(nv[i] + 1), 16'(k));
      wr(4'h2, 16'h0000);
    end
  endtask
  task automatic scn_pins();
    int hi = 0;
    wr(4'hF, 16'h0000);
    wr(4'h3, 16'h0009);
    wr(4'h4, 16'h0008);
    wr(4'h8, 16'h0002);
    wr(4'h1, 16'h000F);
    repeat (64)
    begin
      @(posedge I_MCLK);
      #1 hi += (of === 1'b1);
    end
    chk("pin driven", 16'h0000, {15'h0, ofe});
    chk("second pin driven", 16'h0000, {15'h0, ose});
    chk("pwm toggles", 16'h0001, {15'h0, hi > 0 && hi < 64});
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0001);
    wr(4'h4, 16'h0000);
  endtask
  task automatic scn_irq();
    wr(4'hF, 16'h0000);
    wr(4'hB, 16'h0000);
    wr(4'hC, 16'h0007);
    rd(4'hA);
    chk("status cleared first", 16'h0000, d & 16'h0002);
    wr(4'h9, 16'h0003);
    wr(4'h2, 16'h0007);
    repeat (10) @(posedge I_MCLK);
    wr(4'h2, 16'h0000);
    wr(4'hA, 16'h0000);
    rd(4'hA);
    chk("status sticky", 16'h0002, d & 16'h0002);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(4'hB, 16'h0002);
    #1 chk("irq raised", 16'h0001, {15'h0, irq});
    wr(4'hC, 16'h0002);
    rd(4'hA);
    chk("status cleared", 16'h0000, d & 16'h0002);
    chk("irq cleared", 16'h0000, {15'h0, irq});
  endtask
  // Period capture on INT edges, then timer one parked by a low INT level
  task automatic scn_link();
    wr(4'hF, 16'h0000);
    wr(4'h7, 16'h00FF);
    wr(4'h4, 16'h0002);
    wr(4'h2, 16'h0007);
    repeat (40) @(posedge I_MCLK);
    rd(4'h9);
    chk("period capture", 16'h00F8, {8'h00, d[15:8]});
    wr(4'h2, 16'h0000);
    wr(4'h4, 16'h0000);
    @(negedge intp);
    run <= 1'b0;
    wr(4'h0, 16'h0001);
    wr(4'h8, 16'h0040);
    wr(4'h3, 16'h0003);
    wr(4'h1, 16'h0005);
    repeat (40) @(posedge I_MCLK);
    rd(4'h8);
    chk("linked timer held", 16'h0040, d);
    @(posedge I_MCLK);
    run <= 1'b1;
    repeat (40) @(posedge I_MCLK);
    rd(4'h8);
    chk("linked timer counts", 16'h0001, {15'h0, d != 16'h0040});
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0001);
  endtask
  task automatic scn_wdog();
    wr(4'hF, 16'h0000);
    repeat (900) @(posedge I_MCLK);
    #1 chk("flag early", 16'h0000, {15'h0, wflag});
    repeat (200) @(posedge I_MCLK);
    #1 chk("flag set", 16'h0001, {15'h0, wflag});
    chk("reset early", 16'h0000, {15'h0, srst});
    repeat (1000) @(posedge I_MCLK);
    #1 chk("system reset", 16'h0001, {15'h0, srst});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge I_MCLK);
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (5) @(posedge I_MCLK);
    I_RST_B <= 1'b1;
    repeat (3) @(posedge I_MCLK);
    scn_reset();
    scn_sources();
    scn_stop();
    scn_period();
    scn_pins();
    scn_irq();
    scn_link();
    scn_wdog();
    conclude();
  end
endmodule // tb
